// ==== design/scs_pkg.sv ====
package scs_pkg;
	// register offsets (byte addresses)
	localparam logic [7:0] SCS_BUF_OFF = 8'h04;
	localparam logic [7:0] SCS_CR_OFF = 8'h08;
	localparam logic [7:0] SCS_MODE_OFF = 8'h0c;
	localparam logic [7:0] SCS_BAUD_OFF = 8'h10;
	localparam logic [7:0] SCS_INT_STAT_OFF = 8'h20;
	localparam logic [7:0] SCS_INT_MASK_OFF = 8'h24;
	// control/status field positions
	localparam int SCS_CR_RX_NINTH = 7;
	localparam int SCS_CR_EVEN = 6;
	localparam int SCS_CR_PARITY_ADD = 5;
	localparam int SCS_CR_OVERRUN = 4;
	localparam int SCS_CR_PAR_UNDER = 3;
	localparam int SCS_CR_FRAMING = 2;
	localparam int SCS_CR_EDGE_SEL = 1;
	localparam int SCS_CR_IO_CLK_SRC = 0;
	// mode register field positions
	localparam int SCS_MODE_TX_NINTH = 7;
	localparam int SCS_MODE_RX_EN = 5;
	localparam int SCS_MODE_FMT_LO = 2;
	// interrupt status bit positions
	localparam int SCS_INT_RX = 0;
	localparam int SCS_INT_TX = 1;
	localparam int SCS_INT_ERR = 2;
	// reset values
	localparam logic [15:0] SCS_BAUD_RESET = 16'h000f;
	localparam logic [2:0] SCS_INT_RESET = 3'h0;
	// timing in 16x oversample ticks; clocked-mode edge and bit counts; shift frame width
	localparam logic [3:0] SCS_MID_TICK = 4'h7;
	localparam logic [3:0] SCS_LAST_TICK = 4'hf;
	localparam logic [4:0] SCS_IO_EDGES = 5'h10;
	localparam logic [3:0] SCS_IO_BITS = 4'h8;
	localparam logic [3:0] SCS_FRAME_W = 4'hc;

	typedef enum logic [1:0] {
		SCS_FMT_IO = 2'b00,
		SCS_FMT_U7 = 2'b01,
		SCS_FMT_U8 = 2'b10,
		SCS_FMT_U9 = 2'b11
	} scs_fmt_t;

	typedef struct packed {
		scs_fmt_t fmt;
		logic even;
		logic parity_add_enable;
		logic shift_edge_select;
		logic io_clock_source;
		logic tx_ninth;
		logic rx_enable;
	} scs_cfg_t;

	localparam scs_cfg_t SCS_CFG_RESET = '{SCS_FMT_IO, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

	typedef struct packed {
		logic overrun;
		logic parity_underrun;
		logic framing;
	} scs_err_t;

	typedef struct packed {
		logic [8:0] data;
		logic parity_bad;
		logic framing_bad;
	} scs_rx_word_t;

	// number of data bits per frame
	function automatic logic [3:0] scs_data_bits(scs_fmt_t fmt);
		case (fmt)
			SCS_FMT_U7: scs_data_bits = 4'h7;
			SCS_FMT_U9: scs_data_bits = 4'h9;
			default: scs_data_bits = 4'h8;
		endcase
	endfunction

	// parity only in the 7- and 8-bit uart formats
	function automatic logic scs_use_parity(scs_cfg_t cfg);
		scs_use_parity = cfg.parity_add_enable &&
			(cfg.fmt == SCS_FMT_U7 || cfg.fmt == SCS_FMT_U8);
	endfunction

	// parity bit: even=1 gives even parity, even=0 odd parity
	function automatic logic scs_parity(logic [8:0] data, scs_fmt_t fmt, logic even);
		logic [8:0] mask;
		mask = (fmt == SCS_FMT_U7) ? 9'h07f : 9'h0ff;
		scs_parity = even ? ^(data & mask) : ~^(data & mask);
	endfunction
endpackage

// ==== design/scs_tx.sv ====
`timescale 1ns/1ps
module scs_tx (
	input wire logic pclk,
	input wire logic presetn,
	input scs_pkg::scs_cfg_t cfg,
	input wire logic tick,
	input wire logic start,
	input wire logic [8:0] start_data,
	input wire logic shift_pulse,
	input wire logic sample_pulse,
	output logic tx_line,
	output logic busy,
	output logic done
);
	typedef enum logic [1:0] {
		SCS_TX_IDLE = 2'b00,
		SCS_TX_UART = 2'b01,
		SCS_TX_IO = 2'b10
	} scs_tx_state_t;

	scs_tx_state_t state;
	logic [11:0] sh;
	logic [3:0] bits_left;
	logic [3:0] tick_cnt;
	logic [11:0] next_frame;
	logic [3:0] n;
	logic p;

	// frame after the start bit: data, optional parity, stop
	always_comb begin
		n = scs_pkg::scs_data_bits(cfg.fmt);
		p = scs_pkg::scs_use_parity(cfg);
		next_frame = {3'h0, start_data};
		if (cfg.fmt == scs_pkg::SCS_FMT_U7)
			next_frame[8:7] = 2'b00;
		else if (cfg.fmt != scs_pkg::SCS_FMT_U9)
			next_frame[8] = 1'b0;
		if (p)
			next_frame[n] = scs_pkg::scs_parity(start_data, cfg.fmt, cfg.even);
		next_frame[n + {3'h0, p}] = 1'b1;
	end

	assign busy = (state != SCS_TX_IDLE);

	// shifter for both the uart and the clocked formats
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= SCS_TX_IDLE;
			sh <= 12'h000;
			bits_left <= 4'h0;
			tick_cnt <= 4'h0;
			tx_line <= 1'b1;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				SCS_TX_IDLE: begin
					tick_cnt <= 4'h0;
					if (start && cfg.fmt == scs_pkg::SCS_FMT_IO) begin
						state <= SCS_TX_IO;
						sh <= {4'h0, start_data[7:0]};
						bits_left <= 4'h0;
					end else if (start) begin
						state <= SCS_TX_UART;
						sh <= next_frame;
						bits_left <= n + {3'h0, p} + 4'h1;
						tx_line <= 1'b0; // start bit
					end
				end
				SCS_TX_UART: if (tick) begin
					tick_cnt <= tick_cnt + 4'h1;
					if (tick_cnt == scs_pkg::SCS_LAST_TICK) begin
						if (bits_left == 4'h0) begin
							state <= SCS_TX_IDLE;
							done <= 1'b1;
						end else begin
							tx_line <= sh[0];
							sh <= sh >> 1;
							bits_left <= bits_left - 4'h1;
						end
					end
				end
				SCS_TX_IO: begin
					if (shift_pulse) begin
						tx_line <= sh[0]; // RULE9 RULE10
						sh <= sh >> 1;
						bits_left <= bits_left + 4'h1;
					end else if (sample_pulse && bits_left == scs_pkg::SCS_IO_BITS) begin
						state <= SCS_TX_IDLE;
						done <= 1'b1;
						tx_line <= 1'b1;
					end
				end
				default: state <= SCS_TX_IDLE;
			endcase
		end
	end
endmodule // scs_tx

// ==== design/scs_rx.sv ====
`timescale 1ns/1ps
module scs_rx (
	input wire logic pclk,
	input wire logic presetn,
	input scs_pkg::scs_cfg_t cfg,
	input wire logic tick,
	input wire logic rx_line,
	input wire logic sample_pulse,
	output scs_pkg::scs_rx_word_t word,
	output logic valid
);
	typedef enum logic [1:0] {
		SCS_RX_IDLE = 2'b00,
		SCS_RX_START = 2'b01,
		SCS_RX_DATA = 2'b10
	} scs_rx_state_t;

	scs_rx_state_t state;
	logic [11:0] sh;
	logic [3:0] bits_left;
	logic [3:0] tick_cnt;
	logic [3:0] io_cnt;
	logic [11:0] next_sh;
	logic [11:0] frame;
	logic [3:0] n;
	logic [3:0] total;
	logic p;

	// align the finished frame to bit 0
	always_comb begin
		n = scs_pkg::scs_data_bits(cfg.fmt);
		p = scs_pkg::scs_use_parity(cfg);
		total = n + {3'h0, p} + 4'h1;
		next_sh = {rx_line, sh[11:1]};
		frame = next_sh >> (scs_pkg::SCS_FRAME_W - total);
	end

	// uart receiver with 16x oversampling, clocked receiver on sample edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= SCS_RX_IDLE;
			sh <= 12'h000;
			bits_left <= 4'h0;
			tick_cnt <= 4'h0;
			io_cnt <= 4'h0;
			word <= '0;
			valid <= 1'b0;
		end else begin
			valid <= 1'b0;
			case (state)
				SCS_RX_IDLE: begin
					tick_cnt <= 4'h0;
					if (!cfg.rx_enable || cfg.fmt != scs_pkg::SCS_FMT_IO)
						io_cnt <= 4'h0;
					if (cfg.rx_enable && cfg.fmt == scs_pkg::SCS_FMT_IO && sample_pulse) begin
						sh <= next_sh; // RULE9 RULE10
						io_cnt <= io_cnt + 4'h1;
						if (io_cnt == scs_pkg::SCS_IO_BITS - 4'h1) begin
							io_cnt <= 4'h0;
							valid <= 1'b1;
							word <= '{{1'b0, next_sh[11:4]}, 1'b0, 1'b0};
						end
					end else if (cfg.rx_enable && cfg.fmt != scs_pkg::SCS_FMT_IO && !rx_line)
						state <= SCS_RX_START;
				end
				SCS_RX_START: if (tick) begin
					tick_cnt <= tick_cnt + 4'h1;
					if (tick_cnt == scs_pkg::SCS_MID_TICK) begin
						tick_cnt <= 4'h0;
						bits_left <= total;
						state <= rx_line ? SCS_RX_IDLE : SCS_RX_DATA;
					end
				end
				SCS_RX_DATA: if (tick) begin
					tick_cnt <= tick_cnt + 4'h1;
					if (tick_cnt == scs_pkg::SCS_LAST_TICK) begin
						sh <= next_sh;
						bits_left <= bits_left - 4'h1;
						if (bits_left == 4'h1) begin
							state <= SCS_RX_IDLE;
							valid <= 1'b1;
							word.data <= frame[8:0] & ((cfg.fmt == scs_pkg::SCS_FMT_U7) ? 9'h07f :
								(cfg.fmt == scs_pkg::SCS_FMT_U8) ? 9'h0ff : 9'h1ff);
							word.parity_bad <= p && (frame[n] !=
								scs_pkg::scs_parity(frame[8:0], cfg.fmt, cfg.even)); // RULE2 RULE3
							word.framing_bad <= !rx_line; // RULE7
						end
					end
				end
				default: state <= SCS_RX_IDLE;
			endcase
		end
	end
endmodule // scs_rx

// ==== design/scs_top.sv ====
// Functional notes
// RULE1: in 9-bit uart format, the ninth received bit reads at control bit 7
// RULE2: parity polarity bit 6: cleared gives odd, set gives even parity
// RULE3: parity enable bit 5 adds parity on transmit and checks it on receive
// RULE4: software uses parity only in 7-bit or 8-bit uart formats
// RULE5: overrun shows as read-only status bit 4, one on error
// RULE6: uart parity error or clocked underrun shows as status bit 3
// RULE7: framing error, a bad stop bit, shows as status bit 2
// RULE8: all three error flags clear when software reads the control register
// RULE9: edge select clear: shift out on falling, sample on rising, idle high
// RULE10: edge select set: shift out on rising, sample on falling edges
// RULE11: software keeps edge select zero while the device drives the clock
// RULE12: clock source bit: zero internal generator, one external clock pin
// RULE13: format field 00 clocked, 01/10/11 select 7/8/9-bit uart framing
// RULE14: control bits 31 to 8 read zero and ignore writes
// RULE15: error flags set on detection and hold until the control read
`timescale 1ns/1ps
module scs_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic tx_line,
	input wire logic rx_line,
	input wire logic serial_clock_in,
	output logic serial_clock_out,
	output logic serial_clock_oe,
	output logic irq
);
	scs_pkg::scs_cfg_t cfg;
	scs_pkg::scs_err_t err;
	scs_pkg::scs_rx_word_t rx_word;
	logic [15:0] baud_div;
	logic [15:0] baud_cnt;
	logic tick;
	logic rx_ninth_bit;
	logic [7:0] rx_data;
	logic rx_full;
	logic [8:0] tx_buf;
	logic tx_buf_full;
	logic tx_busy;
	logic tx_done;
	logic tx_start;
	logic tx_armed;
	logic rx_valid;
	logic [2:0] int_stat;
	logic [2:0] int_mask;
	logic [2:0] int_event;
	logic [2:0] half_cnt;
	logic [4:0] edges_left;
	logic sclk_prev;
	logic sclk_level;
	logic rise;
	logic fall;
	logic shift_pulse;
	logic sample_pulse;
	logic io_mode;
	logic io_int;
	logic io_ext;
	logic clk_start;
	logic wr_done;
	logic rd_done;
	logic underrun;
	logic overrun;
	logic parity_bad;
	logic framing_bad;

	// apb transfer completion strobes
	assign wr_done = psel && penable && pready && pwrite;
	assign rd_done = psel && penable && pready && !pwrite;

	// clocked mode and its clock source
	assign io_mode = (cfg.fmt == scs_pkg::SCS_FMT_IO); // RULE13
	assign io_int = io_mode && !cfg.io_clock_source; // RULE12
	assign io_ext = io_mode && cfg.io_clock_source; // RULE12

	// serial clock edges, from our own clock or from the pin
	assign sclk_level = io_ext ? serial_clock_in : serial_clock_out; // RULE12
	assign rise = sclk_level && !sclk_prev;
	assign fall = !sclk_level && sclk_prev;
	assign shift_pulse = io_mode && (cfg.shift_edge_select ? rise : fall); // RULE9 RULE10
	assign sample_pulse = io_mode && (cfg.shift_edge_select ? fall : rise); // RULE9 RULE10

	// transmit loads from the buffer; internal clock waits for an idle gap
	assign tx_start = tx_buf_full && !tx_busy &&
		(!io_int || edges_left == 5'h00);
	assign clk_start = io_int && !tx_busy && edges_left == 5'h00 &&
		(tx_buf_full || (cfg.rx_enable && !rx_full));

	// error events from the engines
	assign overrun = rx_valid && rx_full; // RULE5
	assign parity_bad = rx_valid && rx_word.parity_bad; // RULE6
	assign underrun = io_ext && shift_pulse && tx_armed && !tx_busy && !tx_buf_full; // RULE6
	assign framing_bad = rx_valid && rx_word.framing_bad; // RULE7
	assign int_event = {overrun || parity_bad || underrun || framing_bad, tx_done, rx_valid};

	scs_tx u_tx (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(cfg),
		.tick(tick),
		.start(tx_start),
		.start_data(tx_buf),
		.shift_pulse(shift_pulse),
		.sample_pulse(sample_pulse),
		.tx_line(tx_line),
		.busy(tx_busy),
		.done(tx_done)
	);

	scs_rx u_rx (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(cfg),
		.tick(tick),
		.rx_line(rx_line),
		.sample_pulse(sample_pulse),
		.word(rx_word),
		.valid(rx_valid)
	);

	// apb answer: zero wait states, read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable && !pready;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				prdata <= 32'h0000_0000; // RULE14
				case (paddr)
					scs_pkg::SCS_BUF_OFF: prdata[7:0] <= rx_data;
					scs_pkg::SCS_CR_OFF: begin
						prdata[scs_pkg::SCS_CR_RX_NINTH] <= rx_ninth_bit; // RULE1
						prdata[scs_pkg::SCS_CR_EVEN] <= cfg.even;
						prdata[scs_pkg::SCS_CR_PARITY_ADD] <= cfg.parity_add_enable;
						prdata[scs_pkg::SCS_CR_OVERRUN] <= err.overrun; // RULE5
						prdata[scs_pkg::SCS_CR_PAR_UNDER] <= err.parity_underrun; // RULE6
						prdata[scs_pkg::SCS_CR_FRAMING] <= err.framing; // RULE7
						prdata[scs_pkg::SCS_CR_EDGE_SEL] <= cfg.shift_edge_select;
						prdata[scs_pkg::SCS_CR_IO_CLK_SRC] <= cfg.io_clock_source;
					end
					scs_pkg::SCS_MODE_OFF: begin
						prdata[scs_pkg::SCS_MODE_TX_NINTH] <= cfg.tx_ninth;
						prdata[scs_pkg::SCS_MODE_RX_EN] <= cfg.rx_enable;
						prdata[scs_pkg::SCS_MODE_FMT_LO +: 2] <= cfg.fmt;
					end
					scs_pkg::SCS_BAUD_OFF: prdata[15:0] <= baud_div;
					scs_pkg::SCS_INT_STAT_OFF: prdata[2:0] <= int_stat;
					scs_pkg::SCS_INT_MASK_OFF: prdata[2:0] <= int_mask;
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// software-written configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= scs_pkg::SCS_CFG_RESET;
			baud_div <= scs_pkg::SCS_BAUD_RESET;
			int_mask <= scs_pkg::SCS_INT_RESET;
		end else if (wr_done) begin
			case (paddr)
				scs_pkg::SCS_CR_OFF: begin
					cfg.even <= pwdata[scs_pkg::SCS_CR_EVEN]; // RULE2
					cfg.parity_add_enable <= pwdata[scs_pkg::SCS_CR_PARITY_ADD]; // RULE3
					cfg.shift_edge_select <= pwdata[scs_pkg::SCS_CR_EDGE_SEL];
					cfg.io_clock_source <= pwdata[scs_pkg::SCS_CR_IO_CLK_SRC];
				end
				scs_pkg::SCS_MODE_OFF: begin
					cfg.tx_ninth <= pwdata[scs_pkg::SCS_MODE_TX_NINTH];
					cfg.rx_enable <= pwdata[scs_pkg::SCS_MODE_RX_EN];
					cfg.fmt <= scs_pkg::scs_fmt_t'(pwdata[scs_pkg::SCS_MODE_FMT_LO +: 2]); // RULE13
				end
				scs_pkg::SCS_BAUD_OFF: baud_div <= pwdata[15:0];
				scs_pkg::SCS_INT_MASK_OFF: int_mask <= pwdata[2:0];
				default: cfg <= cfg;
			endcase
		end
	end

	// error flags: sticky, cleared by a control read, a new error wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			err <= '0;
		else begin
			if (rd_done && paddr == scs_pkg::SCS_CR_OFF)
				err <= '0; // RULE8
			if (overrun)
				err.overrun <= 1'b1; // RULE15
			if (parity_bad || underrun)
				err.parity_underrun <= 1'b1; // RULE15
			if (framing_bad)
				err.framing <= 1'b1; // RULE15
		end
	end

	// receive buffer; an arrival into a full buffer is dropped as overrun
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_data <= 8'h00;
			rx_ninth_bit <= 1'b0;
			rx_full <= 1'b0;
		end else begin
			if (rd_done && paddr == scs_pkg::SCS_BUF_OFF)
				rx_full <= 1'b0;
			if (rx_valid && !rx_full) begin
				rx_data <= rx_word.data[7:0];
				rx_full <= 1'b1;
				if (cfg.fmt == scs_pkg::SCS_FMT_U9)
					rx_ninth_bit <= rx_word.data[8]; // RULE1
			end
		end
	end

	// transmit buffer, first stage of the double buffer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_buf <= 9'h000;
			tx_buf_full <= 1'b0;
			tx_armed <= 1'b0;
		end else begin
			if (tx_start) begin
				tx_buf_full <= 1'b0;
				tx_armed <= io_ext;
			end else if (underrun)
				tx_armed <= 1'b0;
			if (wr_done && paddr == scs_pkg::SCS_BUF_OFF) begin
				tx_buf <= {cfg.tx_ninth, pwdata[7:0]};
				tx_buf_full <= 1'b1;
			end
		end
	end

	// baud generator: one oversample tick every baud_div+1 cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_cnt <= 16'h0000;
			tick <= 1'b0;
		end else begin
			tick <= (baud_cnt >= baud_div); // a lowered divisor wraps at once
			baud_cnt <= (baud_cnt >= baud_div) ? 16'h0000 : baud_cnt + 16'h0001;
		end
	end

	// internal serial clock: idles high, 8 periods per clocked frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_clock_out <= 1'b1;
			serial_clock_oe <= 1'b0;
			half_cnt <= 3'h0;
			edges_left <= 5'h00;
			sclk_prev <= 1'b1;
		end else begin
			serial_clock_oe <= io_int; // RULE12
			sclk_prev <= sclk_level;
			if (!io_int) begin
				serial_clock_out <= 1'b1; // RULE9
				edges_left <= 5'h00;
				half_cnt <= 3'h0;
			end else if (clk_start) begin
				edges_left <= scs_pkg::SCS_IO_EDGES;
				half_cnt <= 3'h0;
			end else if (tick && edges_left != 5'h00) begin
				half_cnt <= half_cnt + 3'h1;
				if (half_cnt == scs_pkg::SCS_MID_TICK[2:0]) begin
					serial_clock_out <= !serial_clock_out;
					edges_left <= edges_left - 5'h01;
				end
			end
		end
	end

	// sticky interrupt status, write one to clear, a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat <= scs_pkg::SCS_INT_RESET;
			irq <= 1'b0;
		end else begin
			if (wr_done && paddr == scs_pkg::SCS_INT_STAT_OFF)
				int_stat <= (int_stat & ~pwdata[2:0]) | int_event;
			else
				int_stat <= int_stat | int_event;
			irq <= |(int_stat & int_mask);
		end
	end
endmodule // scs_top

// ==== testbench/scs_checker.sv ====
`timescale 1ns/1ps
module scs_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tx_line,
	input wire logic serial_clock_out,
	input wire logic serial_clock_oe,
	input wire logic irq
);
	logic [1:0] fmt_w;
	logic [1:0] age;
	logic src_w, edge_w, mask_zero, setup, mapped;
	// request phase and address decode
	assign setup = psel && !penable;
	assign mapped = paddr inside {scs_pkg::SCS_BUF_OFF, scs_pkg::SCS_CR_OFF,
		scs_pkg::SCS_MODE_OFF, scs_pkg::SCS_BAUD_OFF, scs_pkg::SCS_INT_STAT_OFF,
		scs_pkg::SCS_INT_MASK_OFF};
	// shadow of written settings; age counts quiet cycles since the last write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fmt_w <= 2'h0;
			src_w <= 1'b0;
			edge_w <= 1'b0;
			mask_zero <= 1'b1;
			age <= 2'h0;
		end else if (psel && penable && pready && pwrite) begin
			age <= 2'h0;
			if (paddr == scs_pkg::SCS_CR_OFF) begin
				edge_w <= pwdata[1];
				src_w <= pwdata[0];
			end
			if (paddr == scs_pkg::SCS_MODE_OFF) begin
				fmt_w <= pwdata[3:2];
			end
			if (paddr == scs_pkg::SCS_INT_MASK_OFF) begin
				mask_zero <= (pwdata[2:0] == 3'h0);
			end
		end else if (age != 2'h3) begin
			age <= age + 2'h1;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_pready_timing: assert property (setup |=> pready ##1 !pready)
		else $error("pready not a single cycle after setup");
	a_pready_cause: assert property (pready |-> $past(setup))
		else $error("pready without a setup cycle");
	a_unmapped_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (setup && mapped |=> !pslverr)
		else $error("mapped access refused");
	a_reserved_zero: assert property (
		pready && !pwrite && paddr == scs_pkg::SCS_CR_OFF |-> prdata[31:8] == 24'h0)
		else $error("control upper bits not zero");
	a_prdata_hold: assert property (!setup |=> $stable(prdata))
		else $error("read data moved outside setup");
	a_oe_select: assert property (age == 2'h3 |-> serial_clock_oe == (fmt_w == 2'h0 && !src_w))
		else $error("clock drive enable wrong");
	a_shift_stable: assert property ($rose(serial_clock_out) && !edge_w |-> $stable(tx_line))
		else $error("tx changed on a sample edge");
	a_irq_masked: assert property (mask_zero && age == 2'h3 |-> !irq)
		else $error("irq with all sources masked");
	cover property ($rose(irq));
	cover property (pslverr);
	cover property ($rose(serial_clock_out));
	cover property (pready && !pwrite && paddr == scs_pkg::SCS_CR_OFF && prdata[4:2] != 3'h0);
endmodule // scs_checker

bind scs_top scs_checker i_scs_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .tx_line(tx_line), .serial_clock_out(serial_clock_out),
	.serial_clock_oe(serial_clock_oe), .irq(irq));

// ==== testbench/scs_remote.sv ====
`timescale 1ns/1ps
module scs_remote #(
	parameter int BIT_CYC = 16
) (
	input wire logic pclk,
	input wire logic tx_line,
	output logic rx_line,
	output logic serial_clock_in
);
	// lines idle high between frames
	initial begin
		rx_line = 1'b1;
		serial_clock_in = 1'b1;
	end
	// one uart frame: start, data lsb first, optional parity, stop
	task automatic send(input logic [8:0] d, input int nb, input logic pen, input logic par,
		input logic stop);
		int n;
		n = nb + int'(pen) + 2;
		for (int i = 0; i < n; i++) begin
			if (i == 0)
				rx_line <= 1'b0;
			else if (i <= nb)
				rx_line <= d[i - 1];
			else if (i < n - 1)
				rx_line <= par;
			else
				rx_line <= stop;
			repeat (BIT_CYC) @(posedge pclk);
		end
		rx_line <= 1'b1;
		@(posedge pclk);
	endtask
	// take a frame from tx, each bit in its middle; bits stay zero if none starts
	task automatic capture(input int n, output logic [9:0] bits);
		int t;
		bits = 10'h0;
		t = 0;
		while (tx_line === 1'b1 && t < 4000) begin
			@(posedge pclk);
			t++;
		end
		if (tx_line === 1'b0) begin
			repeat (BIT_CYC / 2) @(posedge pclk);
			for (int i = 0; i < n; i++) begin
				repeat (BIT_CYC) @(posedge pclk);
				bits[i] = tx_line;
			end
		end
	endtask
	// eight clock periods: leaving idle is the shift edge, returning is the sample edge
	task automatic ext_clock(input logic idle, output logic [7:0] got);
		serial_clock_in <= idle;
		repeat (BIT_CYC) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			serial_clock_in <= ~idle;
			repeat (BIT_CYC / 2) @(posedge pclk);
			got[i] = tx_line;
			serial_clock_in <= idle;
			repeat (BIT_CYC / 2) @(posedge pclk);
		end
	endtask
endmodule // scs_remote

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_line, rx_line, irq;
	logic serial_clock_in, serial_clock_out, serial_clock_oe, err, ev, pe, prev;
	logic [7:0] paddr, got;
	logic [31:0] pwdata, prdata, r;
	logic [9:0] bits, f, m;
	logic [8:0] d;
	int bad_count, n_checks, seed, nb, n;
	scs_top i_scs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_line(tx_line), .rx_line(rx_line),
		.serial_clock_in(serial_clock_in), .serial_clock_out(serial_clock_out),
		.serial_clock_oe(serial_clock_oe), .irq(irq));
	scs_remote i_scs_remote (.pclk(pclk), .tx_line(tx_line), .rx_line(rx_line),
		.serial_clock_in(serial_clock_in));
	// 250 MHz
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	// one apb transfer: setup, then access held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			bad_count++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v);
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(what, e, r);
	endtask
	// parity bit over the low nb bits: set gives even, clear odd
	function automatic logic exp_par(logic [8:0] v, int nb, logic even);
		logic p;
		p = ^(v & ((9'h1 << nb) - 9'h1));
		return even ? p : ~p;
	endfunction
	// watchdog
	initial begin
		repeat (100000) @(posedge pclk);
		bad_count++;
		conclude();
	end
	initial begin
		seed = 5;
		bad_count = 0;
		n_checks = 0;
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc("cr reset", scs_pkg::SCS_CR_OFF, 32'h0);
		chk("clock oe", 32'h1, {31'h0, serial_clock_oe});
		wr(scs_pkg::SCS_CR_OFF, 32'hffffffff);
		rdc("cr masked", scs_pkg::SCS_CR_OFF, 32'h63);
		apb(1'b0, 8'h3c, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		wr(scs_pkg::SCS_BAUD_OFF, 32'h0);
		wr(scs_pkg::SCS_INT_MASK_OFF, 32'h1);
		// receive 7 and 8 bit frames, both polarities, parity fault, stop fault
		for (int k = 0; k < 4; k++) begin
			ev = k[0];
			nb = k[1] ? 7 : 8;
			d = 9'($random(seed)) & ((9'h1 << nb) - 9'h1);
			wr(scs_pkg::SCS_MODE_OFF, nb == 7 ? 32'h24 : 32'h28);
			wr(scs_pkg::SCS_CR_OFF, {25'h0, ev, 6'h20});
			i_scs_remote.send(d, nb, 1'b1, exp_par(d, nb, ev) ^ (k == 1), k != 2);
			rdc("cr flags", scs_pkg::SCS_CR_OFF, {25'h0, ev, 2'h2, k == 1, k == 2, 2'h0});
			rdc("cr cleared", scs_pkg::SCS_CR_OFF, {25'h0, ev, 6'h20});
			rdc("rx data", scs_pkg::SCS_BUF_OFF, {23'h0, d});
			chk("irq raised", 32'h1, {31'h0, irq});
			rdc("int status", scs_pkg::SCS_INT_STAT_OFF, (k == 1 || k == 2) ? 32'h5 : 32'h1);
			wr(scs_pkg::SCS_INT_STAT_OFF, 32'h7);
			repeat (2) @(posedge pclk);
			chk("irq cleared", 32'h0, {31'h0, irq});
		end
		// a second frame before the buffer is read is dropped
		wr(scs_pkg::SCS_MODE_OFF, 32'h28);
		wr(scs_pkg::SCS_CR_OFF, 32'h0);
		d = 9'($random(seed)) & 9'h0ff;
		i_scs_remote.send(d, 8, 1'b0, 1'b0, 1'b1);
		i_scs_remote.send(~d & 9'h0ff, 8, 1'b0, 1'b0, 1'b1);
		rdc("overrun", scs_pkg::SCS_CR_OFF, 32'h10);
		rdc("kept data", scs_pkg::SCS_BUF_OFF, {23'h0, d});
		// nine bit frames with parity enable set, which must be ignored
		wr(scs_pkg::SCS_MODE_OFF, 32'h2c);
		wr(scs_pkg::SCS_CR_OFF, 32'h20);
		for (int k = 0; k < 2; k++) begin
			d = {~k[0], 8'($random(seed))};
			i_scs_remote.send(d, 9, 1'b0, 1'b0, 1'b1);
			rdc("ninth bit", scs_pkg::SCS_CR_OFF, {24'h0, d[8], 7'h20});
			rdc("rx low byte", scs_pkg::SCS_BUF_OFF, {24'h0, d[7:0]});
		end
		wr(scs_pkg::SCS_INT_MASK_OFF, 32'h0);
		// transmit with each parity setting, then a nine bit frame
		for (int k = 0; k < 5; k++) begin
			ev = k[0];
			pe = k[1] | (k == 4);
			nb = k == 4 ? 9 : 8;
			d = {k == 4, 8'($random(seed))};
			wr(scs_pkg::SCS_MODE_OFF, k == 4 ? 32'hac : 32'h28);
			wr(scs_pkg::SCS_CR_OFF, {25'h0, ev, pe, 5'h0});
			wr(scs_pkg::SCS_BUF_OFF, {24'h0, d[7:0]});
			n = nb + int'(pe && nb == 8) + 1;
			i_scs_remote.capture(n, bits);
			f = nb == 9 ? {1'b1, d} : pe ? {1'b1, exp_par(d, 8, ev), d[7:0]} : {2'h3, d[7:0]};
			m = (10'h1 << n) - 10'h1;
			chk("tx frame", {22'h0, f & m}, {22'h0, bits & m});
			chk("irq masked", 32'h0, {31'h0, irq});
			repeat (16) @(posedge pclk);
		end
		// clocked mode on the internal clock: sample on rising edges
		wr(scs_pkg::SCS_MODE_OFF, 32'h0);
		wr(scs_pkg::SCS_CR_OFF, 32'h0);
		d = 9'($random(seed)) & 9'h0ff;
		wr(scs_pkg::SCS_BUF_OFF, {23'h0, d});
		n = 0;
		prev = serial_clock_out;
		for (int t = 0; t < 3000 && n < 8; t++) begin
			@(posedge pclk);
			if (serial_clock_out && !prev) begin
				got[n] = tx_line;
				n++;
			end
			prev = serial_clock_out;
		end
		chk("io tx internal", {24'h0, d[7:0]}, {24'h0, got});
		repeat (16) @(posedge pclk);
		chk("clock idle", 32'h1, {31'h0, serial_clock_out});
		// external clock with both edge settings, then clocking with nothing to send
		wr(scs_pkg::SCS_CR_OFF, 32'h1);
		repeat (2) @(posedge pclk);
		chk("clock oe off", 32'h0, {31'h0, serial_clock_oe});
		for (int k = 0; k < 2; k++) begin
			wr(scs_pkg::SCS_CR_OFF, {30'h0, k[0], 1'b1});
			d = 9'($random(seed)) & 9'h0ff;
			wr(scs_pkg::SCS_BUF_OFF, {23'h0, d});
			i_scs_remote.ext_clock(~k[0], got);
			chk("io tx external", {24'h0, d[7:0]}, {24'h0, got});
		end
		i_scs_remote.ext_clock(1'b1, got);
		rdc("underrun", scs_pkg::SCS_CR_OFF, 32'h0b);
		conclude();
	end
endmodule // testbench
